// file: rtl/bml_pkg.sv
// Constants for the motor mode and lock detect block
// Overview of operation
// - Phases driven only while coast request low
// - Coast request overrides pulse-width input
// - Coast and brake high select standby
// - Brake turns all low sides on
// - Brake overrides pulse-width and lock detect
// - Standby disables bias, pump, all drives
// - Standby ignores all other control inputs
// - Charge pump fault disables all drives
// - Thermal or undervoltage gate outputs, unlatched
// - Power-up lockout keeps drivers disabled
// - Overvoltage disables synchronous rectification
// - Thermal shutdown with hysteresis, releases later
// - No Hall change for lock period
// - Two-state Hall toggling beyond lock period
// - Lock disables outputs and latches
// - Direction edge clears latched lock
// - Load supply lockout release clears lock
// - Pulse-width low over half period clears
// - Lock period is 127 oscillator cycles
// - Grounded timing pin disables lock detect
// - Pulse-width low whole interval blocks lock
package bml_pkg;
  // ---------------------------------------------
  // Lock timing
  // ---------------------------------------------
  localparam logic [7:0] LOCK_CYCLES = 8'h7F;
  localparam logic [7:0] HALF_LOCK_CYCLES = 8'h3F;
  localparam logic [2:0] HALL_RESET = 3'h0;
  localparam logic [5:0] GATES_OFF = 6'h00;
  localparam logic [2:0] SIDE_ALL = 3'h7;

  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_OFF,
    MODE_BRAKE,
    MODE_LOCKED,
    MODE_RUN
  } mode_type;
endpackage

// file: rtl/bml_mode_lock.sv
// Mode selection, fault gating and locked-rotor detector
`timescale 1ns/100ps
module bml_mode_lock
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host control
  input wire logic coastReq,
  input wire logic brakeReq,
  input wire logic direction,
  input wire logic pwmIn,
  // Hall sensors
  input wire logic [2:0] hall,
  // Commutation pattern: high sides [2:0], low sides [2:0]
  input wire logic [2:0] commHigh,
  input wire logic [2:0] commLow,
  // Fault monitors
  input wire logic chargePumpFault,
  input wire logic thermalHot,
  input wire logic thermalCool,
  input wire logic loadSupplyUv,
  input wire logic chargePumpUv,
  input wire logic loadSupplyOv,
  // Lock oscillator
  input wire logic lockOscTick,
  input wire logic lockTimingCapGrounded,
  // Gate drives
  output logic [2:0] gateHigh,
  output logic [2:0] gateLow,
  // Supply enables and status
  output logic sensorBiasEnable,
  output logic chargePumpEnable,
  output logic syncRectEnable,
  output logic lockFault,
  output logic thermalShutdown,
  output bml_pkg::mode_type mode
);

  // ---------------------------------------------
  // Edge detection of control inputs
  // ---------------------------------------------
  logic prevDir;
  logic prevLoadUv;
  logic standby;
  logic [7:0] lockTimer;
  logic [7:0] pwmLowTimer;
  logic [2:0] hallLast;
  logic [2:0] hallPrior;
  logic pwmSeenHigh;
  logic lockClear;
  logic lockDetect;
  logic hallNew;
  logic outputFault;
  bml_pkg::mode_type next_mode;

  assign standby = coastReq && brakeReq;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prevDir <= 1'b0;
      prevLoadUv <= 1'b1;
    end
    else if (!standby)
    begin
      prevDir <= direction;
      prevLoadUv <= loadSupplyUv;
    end
  end

  assign lockClear = !standby && ((direction != prevDir)
    || (prevLoadUv && !loadSupplyUv)
    || (pwmLowTimer > bml_pkg::HALF_LOCK_CYCLES));

  // ---------------------------------------------
  // Thermal shutdown with hysteresis
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      thermalShutdown <= 1'b0;
    else if (thermalHot)
      thermalShutdown <= 1'b1;
    else if (thermalCool)
      thermalShutdown <= 1'b0;
  end

  // ---------------------------------------------
  // Hall history and lock timer
  // ---------------------------------------------
  assign hallNew = (hall != hallLast) && (hall != hallPrior);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hallLast <= bml_pkg::HALL_RESET;
      hallPrior <= bml_pkg::HALL_RESET;
    end
    else if (hall != hallLast)
    begin
      hallPrior <= hallLast;
      hallLast <= hall;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockTimer <= 8'h00;
      pwmSeenHigh <= 1'b0;
    end
    else if (brakeReq || coastReq || lockTimingCapGrounded || hallNew
      || lockFault)
    begin
      lockTimer <= 8'h00;
      pwmSeenHigh <= pwmIn;
    end
    else
    begin
      if (pwmIn)
        pwmSeenHigh <= 1'b1;
      if (lockOscTick && lockTimer != bml_pkg::LOCK_CYCLES)
        lockTimer <= lockTimer + 8'h01;
    end
  end

  assign lockDetect = (lockTimer == bml_pkg::LOCK_CYCLES) && pwmSeenHigh;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pwmLowTimer <= 8'h00;
    else if (pwmIn || standby)
      pwmLowTimer <= 8'h00;
    else if (lockOscTick && pwmLowTimer != bml_pkg::LOCK_CYCLES)
      pwmLowTimer <= pwmLowTimer + 8'h01;
  end

  // ---------------------------------------------
  // Lock fault latch
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lockFault <= 1'b0;
    else if (lockDetect)
      lockFault <= 1'b1;
    else if (lockClear)
      lockFault <= 1'b0;
  end

  // ---------------------------------------------
  // Mode selection
  // ---------------------------------------------
  assign outputFault = chargePumpFault || thermalShutdown
    || chargePumpUv || loadSupplyUv;

  always_comb
  begin
    if (standby)
      next_mode = bml_pkg::MODE_STANDBY;
    else if (outputFault || coastReq)
      next_mode = bml_pkg::MODE_OFF;
    else if (brakeReq)
      next_mode = bml_pkg::MODE_BRAKE;
    else if (lockFault)
      next_mode = bml_pkg::MODE_LOCKED;
    else
      next_mode = bml_pkg::MODE_RUN;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode <= bml_pkg::MODE_OFF;
    else
      mode <= next_mode;
  end

  // ---------------------------------------------
  // Gate outputs
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gateHigh <= 3'h0;
      gateLow <= 3'h0;
      sensorBiasEnable <= 1'b0;
      chargePumpEnable <= 1'b0;
      syncRectEnable <= 1'b0;
    end
    else
    begin
      sensorBiasEnable <= !standby;
      chargePumpEnable <= !standby;
      syncRectEnable <= !loadSupplyOv;
      case (next_mode)
        bml_pkg::MODE_BRAKE:
        begin
          gateHigh <= 3'h0;
          gateLow <= bml_pkg::SIDE_ALL;
        end
        bml_pkg::MODE_RUN:
        begin
          gateHigh <= pwmIn ? commHigh : 3'h0;
          gateLow <= (pwmIn || !loadSupplyOv) ? commLow : 3'h0;
        end
        default:
        begin
          gateHigh <= 3'h0;
          gateLow <= 3'h0;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  property p_coast_off;
    @(posedge clk) disable iff (!rst_n)
    coastReq |=> (gateHigh == 3'h0 && gateLow == 3'h0);
  endproperty
  a_coast_off: assert property (p_coast_off)
    else $error("Gates on while coasting");

  property p_pwm_no_effect;
    @(posedge clk) disable iff (!rst_n)
    (coastReq && $rose(pwmIn)) |=> gateHigh == 3'h0;
  endproperty
  a_pwm_no_effect: assert property (p_pwm_no_effect)
    else $error("Pulse-width drove gate while coasting");

  property p_standby;
    @(posedge clk) disable iff (!rst_n)
    (coastReq && brakeReq) |=> (mode == bml_pkg::MODE_STANDBY
      && !sensorBiasEnable && !chargePumpEnable);
  endproperty
  a_standby: assert property (p_standby)
    else $error("Standby not entered");

  property p_brake;
    @(posedge clk) disable iff (!rst_n)
    (brakeReq && !coastReq && !outputFault) |=>
      (gateLow == 3'h7 && gateHigh == 3'h0);
  endproperty
  a_brake: assert property (p_brake)
    else $error("Brake pattern wrong");

  property p_fault_off;
    @(posedge clk) disable iff (!rst_n)
    (chargePumpFault || chargePumpUv || loadSupplyUv) |=>
      (gateHigh == 3'h0 && gateLow == 3'h0);
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("Gates on during fault");

  property p_thermal_off;
    @(posedge clk) disable iff (!rst_n)
    thermalShutdown |=> (gateHigh == 3'h0 && gateLow == 3'h0);
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("Gates on during thermal shutdown");

  property p_lock_off;
    @(posedge clk) disable iff (!rst_n)
    (lockFault && !brakeReq) |=> (gateHigh == 3'h0 && gateLow == 3'h0);
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("Gates on with lock fault latched");

  property p_lock_latch;
    @(posedge clk) disable iff (!rst_n)
    (lockFault && !lockClear) |=> lockFault;
  endproperty
  a_lock_latch: assert property (p_lock_latch)
    else $error("Lock fault dropped");

  property p_dir_clear;
    @(posedge clk) disable iff (!rst_n)
    ($changed(direction) && !standby && !$past(standby) && !lockDetect)
      |=> !lockFault;
  endproperty
  a_dir_clear: assert property (p_dir_clear)
    else $error("Direction edge did not clear lock");

  property p_grounded;
    @(posedge clk) disable iff (!rst_n)
    lockTimingCapGrounded |=> lockTimer == 8'h00;
  endproperty
  a_grounded: assert property (p_grounded)
    else $error("Lock timer ran with pin grounded");

  property p_ov_norect;
    @(posedge clk) disable iff (!rst_n)
    (loadSupplyOv && !pwmIn && next_mode == bml_pkg::MODE_RUN) |=>
      gateLow == 3'h0;
  endproperty
  a_ov_norect: assert property (p_ov_norect)
    else $error("Rectification during overvoltage");

  c_brake: cover property (@(posedge clk) mode == bml_pkg::MODE_BRAKE);
  c_lock: cover property (@(posedge clk) $rose(lockFault));
  c_standby: cover property (@(posedge clk)
    mode == bml_pkg::MODE_STANDBY);
  c_run: cover property (@(posedge clk) mode == bml_pkg::MODE_RUN);

endmodule // bml_mode_lock

// file: bench/bml_host_model.sv
// Host side model: Hall sensors and lock oscillator
`timescale 1ns/100ps
module bml_host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Rotor behaviour
  input wire logic spin,
  input wire logic wobble,
  // Sensors and oscillator
  output logic [2:0] hall,
  output logic lockOscTick
);
  logic [2:0] div;
  logic [2:0] pos;
  // Oscillator pulse every other clock
  always_ff @(negedge clk or negedge rst_n)
    if (!rst_n) lockOscTick <= 1'h0;
    else lockOscTick <= ~lockOscTick;
  // Rotor step every eight clocks
  always_ff @(negedge clk or negedge rst_n)
    if (!rst_n)
    begin
      div <= 3'h0;
      pos <= 3'h0;
    end
    else
    begin
      div <= div + 3'h1;
      if (div == 3'h7 && wobble) pos <= {2'h0, ~pos[0]};
      else if (div == 3'h7 && spin) pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
    end
  // Six valid Hall states
  always_comb
    case (pos)
      3'h0: hall = 3'h5;
      3'h1: hall = 3'h4;
      3'h2: hall = 3'h6;
      3'h3: hall = 3'h2;
      3'h4: hall = 3'h3;
      default: hall = 3'h1;
    endcase
endmodule // bml_host_model

// file: bench/testbench.sv
// Self-checking bench for the mode and lock detect block
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst_n = 0, coastReq = 0, brakeReq = 0, direction = 0;
  logic pwmIn = 0, chargePumpFault = 0, thermalHot = 0, thermalCool = 1;
  logic loadSupplyUv = 0, chargePumpUv = 0, loadSupplyOv = 0;
  logic lockTimingCapGrounded = 0, spin = 1, wobble = 0;
  logic [2:0] commHigh = 0, commLow = 0, hall, gateHigh, gateLow;
  logic lockOscTick, sensorBiasEnable, chargePumpEnable, syncRectEnable;
  logic lockFault, thermalShutdown, mLock = 0, mHot = 0;
  bml_pkg::mode_type mode;
  int bad_count = 0, compares = 0;
  bml_mode_lock i_bml_mode_lock (.*);
  bml_host_model i_bml_host_model (.*);
  always #5 clk = ~clk;
  // Thermal reference with hysteresis
  always @(posedge clk or negedge rst_n)
    if (!rst_n) mHot <= 0;
    else if (thermalHot) mHot <= 1;
    else if (thermalCool) mHot <= 0;
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("Checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reference mode and gate model
  task check_all;
    bml_pkg::mode_type em;
    logic [2:0] eh, el;
    eh = 0;
    el = 0;
    em = bml_pkg::MODE_RUN;
    if (coastReq & brakeReq) em = bml_pkg::MODE_STANDBY;
    else if (coastReq | chargePumpFault | chargePumpUv | loadSupplyUv | mHot)
      em = bml_pkg::MODE_OFF;
    else if (brakeReq) el = 3'h7;
    else if (mLock) em = bml_pkg::MODE_LOCKED;
    else if (pwmIn) {eh, el} = {commHigh, commLow};
    else if (!loadSupplyOv) el = commLow;
    if (brakeReq && em == bml_pkg::MODE_RUN) em = bml_pkg::MODE_BRAKE;
    chk("mode", 8'(mode), 8'(em));
    chk("gates", {2'h0, gateHigh, gateLow}, {2'h0, eh, el});
    chk("bias", 8'(sensorBiasEnable), 8'(em != bml_pkg::MODE_STANDBY));
    chk("pump", 8'(chargePumpEnable), 8'(em != bml_pkg::MODE_STANDBY));
    chk("lock", 8'(lockFault), 8'(mLock));
    chk("thermal", 8'(thermalShutdown), 8'(mHot));
    chk("syncRect", 8'(syncRectEnable), 8'(!loadSupplyOv));
  endtask
  task run(input int n);
    repeat (n) @(negedge clk);
    check_all;
  endtask
  task lockWait;
    int k;
    k = 0;
    while (lockFault !== 1'b1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    if (lockFault !== 1'b1)
    begin
      bad_count++;
      finish_test;
    end
    mLock = 1;
    run(2);
  endtask
  initial
  begin
    #100000;
    bad_count++;
    finish_test;
  end
  initial
  begin
    logic [15:0] r;
    void'($urandom(32'hca6c_3873));
    repeat (5) @(negedge clk);
    chk("reset", {2'h0, gateHigh, gateLow}, 8'h00);
    chk("resetMode", 8'(mode), 8'(bml_pkg::MODE_OFF));
    rst_n = 1;
    run(2);
    for (int i = 0; i < 60; i++)
    begin
      r = 16'($urandom);
      {coastReq, brakeReq, pwmIn, direction} = r[3:0];
      {chargePumpFault, chargePumpUv, loadSupplyUv, loadSupplyOv} =
        r[7:4] & {4{r[8]}};
      thermalHot = r[10:9] == 2'h0;
      thermalCool = r[10:9] == 2'h3;
      {commHigh, commLow} = 6'($urandom);
      run(2);
    end
    {coastReq, brakeReq, chargePumpFault, chargePumpUv} = 4'h0;
    {loadSupplyUv, loadSupplyOv, thermalHot, thermalCool} = 4'h1;
    {commHigh, commLow} = 6'h0c;
    pwmIn = 1;
    spin = 0;
    run(230);
    lockWait;
    direction = ~direction;
    mLock = 0;
    run(2);
    wobble = 1;
    spin = 1;
    lockWait;
    brakeReq = 1;
    run(2);
    brakeReq = 0;
    pwmIn = 0;
    run(100);
    mLock = 0;
    run(40);
    run(300);
    loadSupplyOv = 1;
    run(2);
    loadSupplyOv = 0;
    pwmIn = 1;
    lockTimingCapGrounded = 1;
    run(300);
    lockTimingCapGrounded = 0;
    lockWait;
    loadSupplyUv = 1;
    run(2);
    loadSupplyUv = 0;
    mLock = 0;
    run(2);
    finish_test;
  end
endmodule // testbench
